// >>> dv/pcs_checker.sv
// Port checker for pcs_switch_ctrl.
// Assumes the bind below; checks pause while clkEn is low.
`timescale 1ns/1ps
module pcs_checker #(
  parameter int LARGE_VARIANT     = 1,
  parameter int OFF_TIMEOUT_CYC   = 20,
  parameter int LATCH_TIMEOUT_CYC = 20
) (
  // Clock and reset
  input wire logic                core_clk,
  input wire logic                reset_n,
  input wire logic                clkEn,
  // Watched pins
  input wire logic                ctrlLine,
  input wire logic [5:0]          switchOn,
  input wire pcs_pkg::pcs_status_s status
);
  int hiCnt;
  int loCnt;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hiCnt <= 0;
      loCnt <= 0;
    end else if (!clkEn) begin
      hiCnt <= 0;
      loCnt <= 0;
    end else begin
      hiCnt <= ctrlLine ? hiCnt + 1 : 0;
      loCnt <= ctrlLine ? 0 : loCnt + 1;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n || !clkEn);
  chk_off_zero: assert property (
    loCnt > OFF_TIMEOUT_CYC + 6 |-> switchOn == 6'h00) else $error("on");
  chk_dis_open: assert property (
    !status.enabled |-> switchOn == 6'h00) else $error("open");
  chk_small_top: assert property (
    LARGE_VARIANT == 0 |-> switchOn[5:3] == 3'h0) else $error("top");
  chk_wake_up: assert property (
    $rose(ctrlLine) && !status.enabled |-> ##[2:8] status.enabled)
    else $error("wake");
  chk_latch_wait: assert property (
    $changed(switchOn) && switchOn != 6'h00 &&
    switchOn != ((LARGE_VARIANT != 0) ? 6'h3f : 6'h07)
    |-> hiCnt >= LATCH_TIMEOUT_CYC) else $error("early");
  chk_hold_set: assert property (
    hiCnt > LATCH_TIMEOUT_CYC + 8 |-> $stable(switchOn)) else $error("hold");
  chk_pat_match: assert property (
    LARGE_VARIANT != 0 && hiCnt > LATCH_TIMEOUT_CYC + 8 && status.enabled
    |-> status.pattern == switchOn) else $error("pattern");
  chk_low_quiet: assert property (
    (!ctrlLine [*8] ##1 $changed(switchOn)) |-> switchOn == 6'h00)
    else $error("quiet");
  cover property (hiCnt == LATCH_TIMEOUT_CYC + 9 && status.enabled);
  cover property ($fell(status.enabled));
  cover property ($rose(ctrlLine) && !status.enabled);
endmodule
bind pcs_switch_ctrl pcs_checker #(.LARGE_VARIANT(LARGE_VARIANT),
  .OFF_TIMEOUT_CYC(OFF_TIMEOUT_CYC), .LATCH_TIMEOUT_CYC(LATCH_TIMEOUT_CYC))
  i_chk (.core_clk(core_clk), .reset_n(reset_n), .clkEn(clkEn),
  .ctrlLine(ctrlLine),
  .switchOn(switchOn), .status(status));

// >>> dv/pcs_host.sv
// Host pin model: pulse trains, then the line held.
// Assumes core_clk from the bench; line idles low.
`timescale 1ns/1ps
module pcs_host (
  input wire logic core_clk,
  output logic     ctrlLine
);
  initial ctrlLine = 1'b0;
  // n rising edges, w cycles low and w+1 high; line left high
  task automatic send(input int n, input int w);
    repeat (n) begin
      @(posedge core_clk) ctrlLine <= 1'b0;
      repeat (w) @(posedge core_clk);
      ctrlLine <= 1'b1;
      repeat (w) @(posedge core_clk);
    end
  endtask
  task automatic idle();
    @(posedge core_clk) ctrlLine <= 1'b0;
  endtask
  task automatic hold();
    @(posedge core_clk) ctrlLine <= 1'b1;
  endtask
endmodule

// >>> dv/tb_pcs_switch_ctrl.sv
// Bench for the switch controller, six- and three-channel builds.
// Assumes timeouts shortened to TO cycles; host model drives the line.
`timescale 1ns/1ps
module tb_pcs_switch_ctrl;
  localparam int TO = 20;
  logic                 core_clk = 1'b0;
  logic                 reset_n  = 1'b0;
  logic                 clkEn    = 1'b1;
  logic                 ctrlLine;
  logic [5:0]           switchOn;
  logic [5:0]           smallOn;
  pcs_pkg::pcs_status_s status;
  int                   nErrors = 0;
  int                   checks  = 0;
  initial forever #5 core_clk = ~core_clk;
  pcs_host i_host (.core_clk(core_clk), .ctrlLine(ctrlLine));
  pcs_switch_ctrl #(.LARGE_VARIANT(1), .OFF_TIMEOUT_CYC(TO),
    .LATCH_TIMEOUT_CYC(TO)) i_dut (.core_clk(core_clk), .reset_n(reset_n),
    .clkEn(clkEn), .ctrlLine(ctrlLine), .switchOn(switchOn), .status(status));
  pcs_switch_ctrl #(.LARGE_VARIANT(0), .OFF_TIMEOUT_CYC(TO),
    .LATCH_TIMEOUT_CYC(TO)) i_dut_small (.core_clk(core_clk),
    .reset_n(reset_n), .clkEn(clkEn), .ctrlLine(ctrlLine),
    .switchOn(smallOn), .status());
  task automatic check(input logic [6:0] seen, input logic [6:0] exp);
    checks++;
    if (seen !== exp) begin
      nErrors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, nErrors);
    if (nErrors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Send n edges, wait out the latch, expect total edge count tot
  task automatic latch_check(input int n, input int w, input int tot);
    logic [5:0] exp;
    exp = ~(tot[5:0] - 6'h01);
    i_host.send(n, w);
    repeat (TO + 10) @(posedge core_clk);
    check({status.enabled, switchOn}, {1'b1, exp});
    check({1'b0, smallOn}, {4'h0, exp[2:0]});
  endtask
  task automatic t_off();
    i_host.idle();
    repeat (TO + 10) @(posedge core_clk);
    check({status.enabled, switchOn}, 7'h00);
  endtask
  task automatic t_first();
    i_host.send(1, 4);
    repeat (8) @(posedge core_clk);
    check({status.enabled, switchOn}, 7'h7f);
    repeat (TO + 4) @(posedge core_clk);
    check({status.enabled, switchOn}, 7'h7f);
    t_off();
    $display("t_first done");
  endtask
  task automatic t_table();
    int counts [6] = '{2, 5, 9, 33, 64, 65};
    foreach (counts[i]) begin
      latch_check(counts[i], 4, counts[i]);
      t_off();
    end
    $display("t_table done");
  endtask
  // Frozen enable: a low line must not shut the device down
  task automatic t_freeze();
    clkEn <= 1'b0;
    i_host.idle();
    repeat (TO + 10) @(posedge core_clk);
    check({status.enabled, switchOn}, 7'h7b);
    i_host.hold();
    clkEn <= 1'b1;
    repeat (8) @(posedge core_clk);
    check({status.enabled, switchOn}, 7'h7b);
    $display("t_freeze done");
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    nErrors++;
    report_and_stop();
  end
  initial begin
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_first();
    t_table();
    latch_check(3, 12, 3);
    latch_check(2, 4, 5);
    t_freeze();
    t_off();
    $display("t_slow done");
    report_and_stop();
  end
endmodule

// >>> include/pcs_pkg.sv
// Package for the pulse-count switch controller.
// Assumes a 100 MHz core clock; no software-visible registers.
package pcs_pkg;
  localparam int    CLK_FREQ_MHZ     = 100;
  localparam int    CHANNELS_SMALL   = 3;
  localparam int    CHANNELS_LARGE   = 6;
  localparam int    OFF_TIMEOUT_US   = 500;
  localparam int    LATCH_TIMEOUT_US = 500;
  // Cycle counts are exact: microseconds times MHz
  localparam int    OFF_TIMEOUT_CYC   = OFF_TIMEOUT_US * CLK_FREQ_MHZ;
  localparam int    LATCH_TIMEOUT_CYC = LATCH_TIMEOUT_US * CLK_FREQ_MHZ;
  localparam int    TIMER_W          = 20;
  localparam logic [5:0] COUNT_RESET = 6'h00;
  localparam logic [5:0] SWITCH_ALL_OFF = 6'h00;

  typedef enum logic [1:0] {
    PCS_OFF,
    PCS_COUNTING,
    PCS_LATCHED
  } pcs_state_e;

  typedef struct packed {
    logic       enabled;
    logic [5:0] pattern;
  } pcs_status_s;
endpackage

// >>> src/pcs_switch_ctrl.sv
// Pulse-count switch controller: counts rising edges on the control
// line, latches a switch pattern after a high timeout, shuts down after
// a low timeout. Assumes the control line is asynchronous to core_clk.
// Contract
// - Rising edges on the control line are counted and set the switches.
// - Host holds the line high after the last pulse; device then latches.
// - The first rising edge enables the device with all switches on.
// - Edges at up to 1 MHz are counted correctly.
// - Each on channel grounds its load; small variant 3, large 6.
// - Counted data latches only after the line stays high for the timeout.
// - After 500 us low the device disables and opens every switch.
// - The three-channel counter wraps after eight edges.
// - The six-channel variant decodes sixty-four switch states.
`timescale 1ns/1ps
module pcs_switch_ctrl #(
  parameter int LARGE_VARIANT     = 1,
  parameter int OFF_TIMEOUT_CYC   = pcs_pkg::OFF_TIMEOUT_CYC,
  parameter int LATCH_TIMEOUT_CYC = pcs_pkg::LATCH_TIMEOUT_CYC
) (
  // Clock, reset, enable
  input  wire logic          core_clk,
  input  wire logic          reset_n,
  input  wire logic          clkEn,
  // Control line from host pin
  input  wire logic          ctrlLine,
  // Switch gates, bit 0 is channel one
  output logic [5:0]         switchOn,
  output pcs_pkg::pcs_status_s status
);
  logic rstMeta;
  logic rstSyncN;
  logic lineMeta;
  logic lineSync;
  logic lineLast;
  logic riseEdge;
  logic offDone;
  logic latDone;
  logic latchLevel;
  logic latchFire;
  logic wakeEdge;
  logic [5:0] edgeCount;
  logic [5:0] countMask;
  logic [5:0] next_pattern;
  logic [5:0] latchedCount;
  pcs_pkg::pcs_state_e state;

  // Reset release through two flops
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta  <= 1'b0;
      rstSyncN <= 1'b0;
    end else begin
      rstMeta  <= 1'b1;
      rstSyncN <= rstMeta;
    end
  end

  // Pin synchroniser; 10 ns sampling resolves 1 MHz pulses
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      lineMeta <= 1'b0;
      lineSync <= 1'b0;
      lineLast <= 1'b0;
    end else if (clkEn) begin
      lineMeta <= ctrlLine;
      lineSync <= lineMeta;
      lineLast <= lineSync;
    end
  end

  assign riseEdge = lineSync & ~lineLast;
  assign wakeEdge = riseEdge & (state == pcs_pkg::PCS_OFF);

  // High time only counts while pulses are being taken
  assign latchLevel = lineSync & (state == pcs_pkg::PCS_COUNTING);
  // Off timeout wins over a latch in the same cycle
  assign latchFire  = latDone & ~offDone &
                      (state == pcs_pkg::PCS_COUNTING);

  pcs_timer #(
    .LIMIT (OFF_TIMEOUT_CYC)
  ) offTimer (
    .core_clk (core_clk),
    .rstSyncN (rstSyncN),
    .clkEn    (clkEn),
    .level    (~lineSync),
    .done     (offDone)
  );

  pcs_timer #(
    .LIMIT (LATCH_TIMEOUT_CYC)
  ) latchTimer (
    .core_clk (core_clk),
    .rstSyncN (rstSyncN),
    .clkEn    (clkEn),
    .level    (latchLevel),
    .done     (latDone)
  );

  // Small variant keeps three count bits
  assign countMask = (LARGE_VARIANT != 0) ? 6'h3f : 6'h07;

  // Edge counter holds count-1; wraps naturally in the masked width
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      edgeCount <= pcs_pkg::COUNT_RESET;
    end else if (clkEn) begin
      if (offDone) begin
        edgeCount <= pcs_pkg::COUNT_RESET;
      end else if (riseEdge) begin
        if (wakeEdge) begin
          edgeCount <= pcs_pkg::COUNT_RESET;
        end else begin
          edgeCount <= (edgeCount + 6'h01) & countMask;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      state <= pcs_pkg::PCS_OFF;
    end else if (clkEn) begin
      unique case (state)
        pcs_pkg::PCS_OFF: begin
          if (wakeEdge) begin
            state <= pcs_pkg::PCS_COUNTING;
          end
        end
        pcs_pkg::PCS_COUNTING: begin
          if (offDone) begin
            state <= pcs_pkg::PCS_OFF;
          end else if (latchFire) begin
            state <= pcs_pkg::PCS_LATCHED;
          end
        end
        pcs_pkg::PCS_LATCHED: begin
          if (offDone) begin
            state <= pcs_pkg::PCS_OFF;
          end else if (riseEdge) begin
            state <= pcs_pkg::PCS_COUNTING;
          end
        end
      endcase
    end
  end

  // Count captured once the high timeout expires; shutdown forgets it
  // so the next wake-up starts with every switch on
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      latchedCount <= pcs_pkg::COUNT_RESET;
    end else if (clkEn) begin
      if (offDone) begin
        latchedCount <= pcs_pkg::COUNT_RESET;
      end else if (latchFire) begin
        latchedCount <= edgeCount;
      end
    end
  end

  // Decode: set bit in count-1 opens that channel
  for (genvar k = 0; k < pcs_pkg::CHANNELS_LARGE; k++) begin : g_chan
    if (k < pcs_pkg::CHANNELS_SMALL || LARGE_VARIANT != 0) begin : g_used
      assign next_pattern[k] = ~latchedCount[k];
    end else begin : g_unused
      assign next_pattern[k] = 1'b0;
    end
  end

  // All on while counting after enable; pattern once latched
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      switchOn <= pcs_pkg::SWITCH_ALL_OFF;
    end else if (clkEn) begin
      unique case (state)
        pcs_pkg::PCS_OFF: begin
          switchOn <= pcs_pkg::SWITCH_ALL_OFF;
        end
        pcs_pkg::PCS_COUNTING: begin
          if (latchedCount == pcs_pkg::COUNT_RESET) begin
            switchOn <= countMask;
          end
        end
        pcs_pkg::PCS_LATCHED: begin
          switchOn <= next_pattern;
        end
      endcase
    end
  end

  // Status mirrors state and decoded pattern
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      status <= '0;
    end else if (clkEn) begin
      status.enabled <= (state != pcs_pkg::PCS_OFF);
      status.pattern <= next_pattern;
    end
  end
endmodule

// >>> src/pcs_timer.sv
// Timeout counter: raises done after the input level held for LIMIT cycles.
// Assumes a synchronous, already-filtered level input.
`timescale 1ns/1ps
module pcs_timer #(
  parameter int LIMIT = 50000
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rstSyncN,
  input  wire logic clkEn,
  // Level to time
  input  wire logic level,
  output logic      done
);
  logic [pcs_pkg::TIMER_W-1:0] count;

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      count <= '0;
      done  <= 1'b0;
    end else if (clkEn) begin
      if (!level) begin
        count <= '0;
        done  <= 1'b0;
      end else if (count >= pcs_pkg::TIMER_W'(LIMIT - 1)) begin
        done <= 1'b1;
      end else begin
        count <= count + 1'b1;
      end
    end
  end
endmodule
